// *** common/cwp_pkg.sv ***
// Constants, types and helpers shared by the configuration word block
package cwp_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [13:0] IDX_PM_LAST  = 14'h0FFF;
  localparam logic [13:0] IDX_USER_ID0 = 14'h2000;
  localparam logic [13:0] IDX_USER_ID3 = 14'h2003;
  localparam logic [13:0] IDX_PART_ID  = 14'h2006;
  localparam logic [13:0] IDX_CONFIG   = 14'h2007;
  localparam logic [13:0] IDX_CONTROL  = 14'h2010;
  localparam logic [13:0] IDX_STATUS   = 14'h2011;

  // ----------------------------------------------------------------
  // Configuration word layout
  // ----------------------------------------------------------------
  localparam int          CFG_W          = 14;
  localparam int          BIT_DEBUG_N    = 13;
  localparam int          BIT_WRT_HI     = 11;
  localparam int          BIT_WRT_LO     = 10;
  localparam int          BIT_CODE_N     = 6;
  localparam int          BIT_RST_PIN    = 5;
  localparam int          BIT_POWERUP_TIMER_N     = 4;
  localparam int          BIT_WDT        = 3;
  localparam logic [13:0] CFG_UNIMPL     = 14'h1387;
  localparam logic [13:0] CFG_ERASED     = 14'h3FFF;

  // Identification word layout
  localparam int          PART_LSB       = 5;
  localparam int          PART_W         = 9;
  localparam int          REV_W          = 5;

  // Control register bits
  localparam int          CTL_PROG_MODE  = 0;
  localparam int          CTL_RELOAD     = 1;

  // Self-write protect limits
  localparam logic [1:0]  WRT_OFF        = 2'h3;
  localparam logic [1:0]  WRT_LOW_1K     = 2'h2;
  localparam logic [1:0]  WRT_LOW_2K     = 2'h1;
  localparam logic [11:0] WRT_LIMIT_1K   = 12'h400;
  localparam logic [11:0] WRT_LIMIT_2K   = 12'h800;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_KHZ        = 10000;
  localparam int          POWERUP_TIMER_MS        = 64;
  localparam int          POWERUP_TIMER_CYCLES    = POWERUP_TIMER_MS * CLK_KHZ;

  // AHB
  localparam logic        HRESP_OKAY     = 1'b0;

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       debug_en;
    logic [1:0] wrt_sel;
    logic       code_protect_en;
    logic       reset_pin_ext;
    logic       powerup_timer_en;
    logic       wdt_en;
  } cwp_cfg_s;

  // Self-write blocked for this program address
  function automatic logic self_wr_blocked(input logic [1:0] wrt, input logic [11:0] addr);
    unique case (wrt)
      WRT_OFF:    self_wr_blocked = 1'b0;
      WRT_LOW_1K: self_wr_blocked = (addr < WRT_LIMIT_1K);
      WRT_LOW_2K: self_wr_blocked = (addr < WRT_LIMIT_2K);
      default:    self_wr_blocked = 1'b1;
    endcase
  endfunction

endpackage

// *** verilog/cwp_decode.sv ***
// Decoder from stored configuration word to enables and readback value
`timescale 1ns/1ns
`default_nettype none

module cwp_decode
(
  input  wire logic [13:0]      cfg_word,
  output cwp_pkg::cwp_cfg_s     cfg,
  output logic      [13:0]      cfg_readback
);

  always_comb
  begin
    cfg.debug_en        = ~cfg_word[cwp_pkg::BIT_DEBUG_N];
    cfg.wrt_sel         = cfg_word[cwp_pkg::BIT_WRT_HI:cwp_pkg::BIT_WRT_LO];
    cfg.code_protect_en = ~cfg_word[cwp_pkg::BIT_CODE_N];
    cfg.reset_pin_ext   = cfg_word[cwp_pkg::BIT_RST_PIN];
    cfg.powerup_timer_en         = ~cfg_word[cwp_pkg::BIT_POWERUP_TIMER_N];
    cfg.wdt_en          = cfg_word[cwp_pkg::BIT_WDT];
    cfg_readback        = cfg_word | cwp_pkg::CFG_UNIMPL;
  end

endmodule
`default_nettype wire

// *** verilog/cwp_top.sv ***
// Configuration word, identification word and memory protection with AHB-Lite access
//
// Function
// - Configuration word lives at 2007h
// - Bit 13 low enables in-circuit debug
// - Unimplemented config bits read as one
// - Bits 11:10 choose self-write protected range
// - Unprotected self-writes only via control mechanism
// - Code protect blocks external access, reads zero
// - CPU program reads unaffected by protection
// - Bit 5 high: external reset pin, pull-up
// - Bit 5 low: alternate pin function
// - Bit 4 low enables power-up timer
// - Bit 3 high enables watchdog
// - Four user ID words at 2000h-2003h
// - ID words only in program/verify mode
// - Identification word lives at 2006h
// - Part id bits 13:5, revision 4:0
// - Writes to identification word ignored
// - Power-up timer holds reset 64 ms
`timescale 1ns/1ns
`default_nettype none

module cwp_top
#(
  parameter int unsigned POWERUP_TIMER_CYCLES = cwp_pkg::POWERUP_TIMER_CYCLES,
  // Arbitrary identification values
  parameter logic [8:0]  PART_ID     = 9'h0A5,
  parameter logic [4:0]  REV_ID      = 5'h03
)
(
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic      [31:0]   hrdata,
  // External program memory path
  output logic      [11:0]   pm_ext_addr,
  output logic      [13:0]   pm_ext_wdata,
  output logic               pm_ext_we,
  input  wire logic [13:0]   pm_ext_rdata,
  // CPU self-write path
  input  wire logic          cpu_wr_req,
  input  wire logic [11:0]   cpu_wr_addr,
  input  wire logic          program_memory_control,
  output logic               cpu_wr_grant,
  output logic               cpu_wr_blocked,
  // Reset and timer side
  input  wire logic          reset_event,
  input  wire logic          external_reset_pin_n,
  output logic               ext_reset_req,
  output logic               reset_pin_pullup_en,
  output logic               reset_pin_alt_func,
  output logic               chip_hold_reset,
  output cwp_pkg::cwp_cfg_s  active_cfg
);

  localparam int CNT_W = $clog2(POWERUP_TIMER_CYCLES + 1);

  // ------------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------------
  if (POWERUP_TIMER_CYCLES < 1)
  begin : g_chk
    $error("POWERUP_TIMER_CYCLES must be at least one");
  end

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  // Stands in for non-volatile cells: erased at power-up, kept through resets
  logic      [13:0]  cfg_word_q = cwp_pkg::CFG_ERASED;
  logic      [13:0]  user_id_q [4];
  logic              prog_mode_q;
  logic              reload_q;
  logic              load_pend_q;
  cwp_pkg::cwp_cfg_s cfg_q;
  cwp_pkg::cwp_cfg_s cfg_d;
  logic      [13:0]  cfg_readback;
  logic [CNT_W-1:0]  powerup_timer_cnt_q;

  // ------------------------------------------------------------------
  // AHB address and data phase tracking
  // ------------------------------------------------------------------
  logic              wr_pend_q;
  logic              rd_pend_q;
  logic              rd_done_q;
  logic      [13:0]  idx_q;
  logic              accept;
  logic      [31:0]  rd_mux;

  assign accept = hsel & htrans[1] & hready;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      idx_q     <= 14'h0000;
    end
    else if (accept)
    begin
      wr_pend_q <= hwrite;
      rd_pend_q <= ~hwrite;
      idx_q     <= haddr[15:2];
    end
    else if (hready)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end
  end

  // Read takes one wait state so data comes from a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_done_q <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      rd_done_q <= rd_pend_q & ~rd_done_q;
      if (rd_pend_q & ~rd_done_q)
      begin
        hrdata <= rd_mux;
      end
    end
  end

  assign hreadyout = ~(rd_pend_q & ~rd_done_q);
  assign hresp     = cwp_pkg::HRESP_OKAY;

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  logic wr_now;
  logic is_pm;
  logic is_uid;
  logic pm_ok;

  assign wr_now = wr_pend_q & hready;
  assign is_pm  = (idx_q <= cwp_pkg::IDX_PM_LAST);
  assign is_uid = (idx_q >= cwp_pkg::IDX_USER_ID0) && (idx_q <= cwp_pkg::IDX_USER_ID3);
  assign pm_ok  = prog_mode_q & ~cfg_q.code_protect_en;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (is_pm)
    begin
      rd_mux[13:0] = pm_ok ? pm_ext_rdata : 14'h0000;
    end
    else if (is_uid)
    begin
      rd_mux[13:0] = prog_mode_q ? user_id_q[idx_q[1:0]] : 14'h0000;
    end
    else
    begin
      unique case (idx_q)
        cwp_pkg::IDX_PART_ID: rd_mux[13:0] = {PART_ID, REV_ID};
        cwp_pkg::IDX_CONFIG:  rd_mux[13:0] = cfg_readback;
        cwp_pkg::IDX_CONTROL: rd_mux[0]    = prog_mode_q;
        cwp_pkg::IDX_STATUS:  rd_mux[7:0]  = {(powerup_timer_cnt_q != '0), cfg_q};
        default:              rd_mux       = 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // External program memory path
  // ------------------------------------------------------------------
  assign pm_ext_addr  = idx_q[11:0];
  assign pm_ext_wdata = hwdata[13:0];
  assign pm_ext_we    = wr_now & is_pm & pm_ok;

  // ------------------------------------------------------------------
  // Control register and stored words
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prog_mode_q <= 1'b0;
      reload_q    <= 1'b0;
    end
    else
    begin
      reload_q <= 1'b0;
      if (wr_now && idx_q == cwp_pkg::IDX_CONTROL)
      begin
        prog_mode_q <= hwdata[cwp_pkg::CTL_PROG_MODE];
        reload_q    <= hwdata[cwp_pkg::CTL_RELOAD];
      end
    end
  end

  // Programming writes land in the stored word only; the identification word has no write path.
  // No reset, so a programmed power-up timer enable is seen by the load after hresetn.
  always_ff @(posedge hclk)
  begin
    if (wr_now && prog_mode_q && idx_q == cwp_pkg::IDX_CONFIG)
    begin
      cfg_word_q <= hwdata[13:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        user_id_q[i] <= cwp_pkg::CFG_ERASED;
      end
    end
    else if (wr_now && prog_mode_q && is_uid)
    begin
      user_id_q[idx_q[1:0]] <= hwdata[13:0];
    end
  end

  cwp_decode u_decode
  (
    .cfg_word     (cfg_word_q),
    .cfg          (cfg_d),
    .cfg_readback (cfg_readback)
  );

  // ------------------------------------------------------------------
  // Active configuration latch
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      load_pend_q <= 1'b1;
      cfg_q       <= '0;
    end
    else
    begin
      load_pend_q <= 1'b0;
      if (load_pend_q | reset_event | reload_q)
      begin
        cfg_q <= cfg_d;
      end
    end
  end

  assign active_cfg = cfg_q;

  // ------------------------------------------------------------------
  // Power-up timer, started after every hresetn release, not by reset_event
  // ------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      powerup_timer_cnt_q <= '0;
    end
    else if (load_pend_q)
    begin
      powerup_timer_cnt_q <= cfg_d.powerup_timer_en ? CNT_W'(POWERUP_TIMER_CYCLES) : '0;
    end
    else if (powerup_timer_cnt_q != '0)
    begin
      powerup_timer_cnt_q <= powerup_timer_cnt_q - CNT_W'(1);
    end
  end

  assign chip_hold_reset = load_pend_q | (powerup_timer_cnt_q != '0);

  // ------------------------------------------------------------------
  // Reset pin function
  // ------------------------------------------------------------------
  assign reset_pin_pullup_en = cfg_q.reset_pin_ext;
  assign ext_reset_req       = cfg_q.reset_pin_ext & ~external_reset_pin_n;
  assign reset_pin_alt_func  = ~cfg_q.reset_pin_ext;

  // ------------------------------------------------------------------
  // CPU self-write gate; CPU fetches bypass this block entirely
  // ------------------------------------------------------------------
  logic self_blk;

  assign self_blk       = cwp_pkg::self_wr_blocked(cfg_q.wrt_sel, cpu_wr_addr);
  assign cpu_wr_grant   = cpu_wr_req & program_memory_control & ~self_blk;
  assign cpu_wr_blocked = cpu_wr_req & self_blk;

endmodule
`default_nettype wire

// *** tb/cwp_pm_model.sv ***
// Program memory model behind the external access path
`timescale 1ns/1ns
`default_nettype none

module cwp_pm_model
(
  input  wire logic        hclk,
  input  wire logic [11:0] addr,
  input  wire logic [13:0] wdata,
  input  wire logic        we,
  output logic      [13:0] rdata
);
  logic [13:0] mem [4096];

  // Address-dependent fill so a blocked read never matches by luck
  initial
  begin
    for (int a = 0; a < 4096; a++)
      mem[a] = 14'h3FFF ^ 14'(a);
  end

  assign rdata = mem[addr];

  always @(posedge hclk)
    if (we)
      mem[addr] <= wdata;
endmodule

`default_nettype wire

// *** tb/cwp_top_assertions.sv ***
// Concurrent checks on the configuration block ports
`timescale 1ns/1ns
`default_nettype none

module cwp_chk
#(
  parameter int unsigned HOLD_CYCLES = 20
)
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hwrite,
  input wire logic              pm_ext_we,
  input wire logic              cpu_wr_req,
  input wire logic [11:0]       cpu_wr_addr,
  input wire logic              program_memory_control,
  input wire logic              cpu_wr_grant,
  input wire logic              cpu_wr_blocked,
  input wire logic              reset_event,
  input wire logic              external_reset_pin_n,
  input wire logic              ext_reset_req,
  input wire logic              chip_hold_reset,
  input wire cwp_pkg::cwp_cfg_s active_cfg
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  int unsigned hold_cnt;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hold_cnt <= 0;
    else if (chip_hold_reset)
      hold_cnt <= hold_cnt + 1;

  a_grant_rule: assert property (cpu_wr_grant == (cpu_wr_req && program_memory_control && !cpu_wr_blocked))
    else $error("bad grant");
  a_wrt_off: assert property (active_cfg.wrt_sel == 2'h3 |-> !cpu_wr_blocked)
    else $error("blocked with protection off");
  a_wrt_all: assert property (cpu_wr_req && active_cfg.wrt_sel == 2'h0 |-> cpu_wr_blocked)
    else $error("not blocked with full protection");
  a_wrt_low1k: assert property (cpu_wr_req && active_cfg.wrt_sel == 2'h2 |-> cpu_wr_blocked == (cpu_wr_addr < 12'h400))
    else $error("bad 1k block");
  a_wrt_low2k: assert property (cpu_wr_req && active_cfg.wrt_sel == 2'h1 |-> cpu_wr_blocked == (cpu_wr_addr < 12'h800))
    else $error("bad 2k block");
  a_reset_req: assert property (ext_reset_req == (active_cfg.reset_pin_ext && !external_reset_pin_n))
    else $error("bad reset request");
  a_cp_no_we: assert property (pm_ext_we |-> !active_cfg.code_protect_en)
    else $error("write while protected");
  a_cfg_static: assert property ($changed(active_cfg) |-> !$past(hresetn, 2) || $past(reset_event)
    || $past(reset_event, 2) || $past(hwrite, 2) || $past(hwrite, 3))
    else $error("config changed alone");
  a_hold_len: assert property ($fell(chip_hold_reset) |-> hold_cnt == (active_cfg.powerup_timer_en ? HOLD_CYCLES + 1 : 1))
    else $error("bad hold length");
  a_hold_once: assert property (!$rose(chip_hold_reset))
    else $error("hold restarted");
endmodule

bind cwp_top cwp_chk #(.HOLD_CYCLES(POWERUP_TIMER_CYCLES)) u_chk (.hclk, .hresetn, .hwrite, .pm_ext_we, .cpu_wr_req,
  .cpu_wr_addr, .program_memory_control, .cpu_wr_grant, .cpu_wr_blocked, .reset_event, .external_reset_pin_n,
  .ext_reset_req, .chip_hold_reset, .active_cfg);

`default_nettype wire

// *** tb/tb_cwp_top.sv ***
// Testbench for the configuration block
`timescale 1ns/1ns
`default_nettype none

module tb_cwp_top;
  // Arbitrary identification values
  localparam logic [8:0] P_PART = 9'h0A5;
  localparam logic [4:0] P_REV  = 5'h03;
  localparam int         P_POWERUP_TIMER = 20;

  logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, reset_event = 1'b0;
  logic              cpu_wr_req = 1'b0, program_memory_control = 1'b0, external_reset_pin_n = 1'b1;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [11:0]       cpu_wr_addr = 12'h0, pm_ext_addr;
  logic [13:0]       pm_ext_wdata, pm_ext_rdata, c;
  logic [13:0]       m_cfg = 14'h3FFF;
  logic              hready, hreadyout, hresp, pm_ext_we, cpu_wr_grant, cpu_wr_blocked, m_prog;
  logic              ext_reset_req, reset_pin_pullup_en, reset_pin_alt_func, chip_hold_reset;
  logic [13:0]       m_uid [4];
  logic [13:0]       m_pm [logic [13:0]];
  logic [6:0]        m_act;
  cwp_pkg::cwp_cfg_s active_cfg;
  int unsigned       seed = 38, miscompares = 0, total_checks = 0, cyc = 0;

  assign hready = hreadyout;
  always #50 hclk = ~hclk;

  cwp_top #(.POWERUP_TIMER_CYCLES(P_POWERUP_TIMER), .PART_ID(P_PART), .REV_ID(P_REV)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pm_ext_addr, .pm_ext_wdata, .pm_ext_we,
    .pm_ext_rdata, .cpu_wr_req, .cpu_wr_addr, .program_memory_control, .cpu_wr_grant, .cpu_wr_blocked,
    .reset_event, .external_reset_pin_n, .ext_reset_req, .reset_pin_pullup_en, .reset_pin_alt_func,
    .chip_hold_reset, .active_cfg);
  cwp_pm_model pm (.hclk, .addr(pm_ext_addr), .wdata(pm_ext_wdata), .we(pm_ext_we), .rdata(pm_ext_rdata));

  function int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [6:0] dec(input logic [13:0] w);
    return {~w[13], w[11:10], ~w[6], w[5], ~w[4], w[3]};
  endfunction

  function automatic logic [31:0] exp_rd(input logic [13:0] i);
    logic [31:0] v;
    v = 32'h0;
    if (i <= 14'h0FFF && m_prog && !m_act[3])
      v[13:0] = m_pm.exists(i) ? m_pm[i] : 14'h3FFF ^ i;
    if (i == cwp_pkg::IDX_PART_ID)
      v[13:0] = {P_PART, P_REV};
    if (i == cwp_pkg::IDX_CONFIG)
      v[13:0] = m_cfg | 14'h1387;
    if (i >= cwp_pkg::IDX_USER_ID0 && i <= cwp_pkg::IDX_USER_ID3 && m_prog)
      v[13:0] = m_uid[i[1:0]];
    if (i == cwp_pkg::IDX_CONTROL)
      v[0] = m_prog;
    if (i == cwp_pkg::IDX_STATUS)
      v[6:0] = m_act;
    return v;
  endfunction

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Bus master
  // --------------------------------------------------------------
  task automatic xfer(input logic w, input logic [13:0] i, input logic [31:0] d, output logic [31:0] r);
    haddr <= {16'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(negedge hclk); while (hready !== 1'b1);
    @(posedge hclk);
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= d;
    do @(negedge hclk); while (hready !== 1'b1);
    r = hrdata;
    check(hresp, 1'b0);
    @(posedge hclk);
  endtask

  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    logic [31:0] r;
    if (i <= 14'h0FFF && m_prog && !m_act[3])
      m_pm[i] = d[13:0];
    if (m_prog && i == cwp_pkg::IDX_CONFIG)
      m_cfg = d[13:0];
    if (m_prog && i >= cwp_pkg::IDX_USER_ID0 && i <= cwp_pkg::IDX_USER_ID3)
      m_uid[i[1:0]] = d[13:0];
    if (i == cwp_pkg::IDX_CONTROL)
      m_prog = d[0];
    if (i == cwp_pkg::IDX_CONTROL && d[1])
      m_act = dec(m_cfg);
    xfer(1'b1, i, d, r);
  endtask

  task automatic rd(input logic [13:0] i);
    logic [31:0] r;
    xfer(1'b0, i, 32'h0, r);
    check(r, exp_rd(i));
  endtask

  // Stored config word survives reset; hold lasts one cycle plus the timer when enabled
  task automatic do_reset();
    int n;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    m_uid = '{4{14'h3FFF}};
    m_prog = 1'b0;
    m_act = dec(m_cfg);
    n = 0;
    @(negedge hclk);
    while (chip_hold_reset === 1'b1 && n < 100)
    begin
      n++;
      @(negedge hclk);
    end
    check(n, m_act[1] ? P_POWERUP_TIMER + 1 : 1);
    @(posedge hclk);
    done("reset");
  endtask

  // Self-write decisions and reset pin mode, boundary addresses first
  task automatic cpu_chk();
    logic [12:0] lim;
    logic [11:0] a;
    logic        b;
    lim = m_act[5:4] == 2'h3 ? 13'h0 : 13'h1000 >> m_act[5:4];
    for (int k = 0; k < 8; k++)
    begin
      a = k == 0 ? 12'(lim - 13'h1) : k == 1 ? lim[11:0] : 12'(rnd());
      cpu_wr_req <= k != 7;
      cpu_wr_addr <= a;
      program_memory_control <= 1'(rnd());
      external_reset_pin_n <= 1'(rnd());
      @(negedge hclk);
      b = k != 7 && {1'b0, a} < lim;
      check(cpu_wr_blocked, b);
      check(cpu_wr_grant, !b && k != 7 && program_memory_control);
      check(ext_reset_req, m_act[2] & ~external_reset_pin_n);
      check({reset_pin_pullup_en, reset_pin_alt_func}, {m_act[2], ~m_act[2]});
      check(active_cfg, m_act);
      @(posedge hclk);
    end
    cpu_wr_req <= 1'b0;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  initial
  begin
    do_reset();
    rd(cwp_pkg::IDX_STATUS);
    rd(cwp_pkg::IDX_PART_ID);
    wr(cwp_pkg::IDX_CONFIG, 32'h0);
    wr(cwp_pkg::IDX_USER_ID0, 32'h0);
    rd(cwp_pkg::IDX_CONFIG);
    rd(cwp_pkg::IDX_USER_ID0);
    wr(cwp_pkg::IDX_CONTROL, 32'h1);
    for (int k = 0; k < 4; k++)
    begin
      c = 14'(rnd());
      c[13] = k != 3;
      c[11:10] = 2'(k);
      c[6] = k[0];
      wr(cwp_pkg::IDX_CONFIG, 32'(c));
      rd(cwp_pkg::IDX_STATUS);
      wr(cwp_pkg::IDX_CONTROL, 32'h3);
      rd(cwp_pkg::IDX_STATUS);
      rd(cwp_pkg::IDX_CONFIG);
      rd(14'h03C5);
      wr(14'h03C5, rnd());
      rd(14'h03C5);
      wr(cwp_pkg::IDX_USER_ID0 + 14'(k), rnd());
      rd(cwp_pkg::IDX_USER_ID0 + 14'(k));
      cpu_chk();
    end
    wr(cwp_pkg::IDX_PART_ID, rnd());
    rd(cwp_pkg::IDX_PART_ID);
    wr(14'h2005, rnd());
    rd(14'h2005);
    done("access");
    c[4] = 1'b0;
    c[3] = ~c[3];
    wr(cwp_pkg::IDX_CONFIG, 32'(c));
    reset_event <= 1'b1;
    @(posedge hclk);
    reset_event <= 1'b0;
    m_act = dec(c);
    repeat (2) @(negedge hclk);
    check(chip_hold_reset, 1'b0);
    @(posedge hclk);
    rd(cwp_pkg::IDX_STATUS);
    cpu_chk();
    done("reload");
    do_reset();
    rd(cwp_pkg::IDX_CONFIG);
    rd(cwp_pkg::IDX_CONTROL);
    rd(cwp_pkg::IDX_STATUS);
    done("second reset");
    tally_and_finish();
  end
endmodule

`default_nettype wire
